// ### src/sdc_core.sv
// Switch-detect command decoder, configuration registers, mode and interrupt logic.
// Assumes an SPI master on sclk/cs_n/si and analog comparators on sw_comp.
// Operation
// - Normal mode entered on power-up, enabled change, wake fall, int fall, cs fall, timer.
// - Registers accept writes only in Normal mode with logic supply present.
// - Switch states latched into status word at chip-select falling edge.
// - Interrupt released at cs rise unless an enabled switch changed while cs low.
// - Code 0x01 loads programmable polarity from bits 7..0; one means battery.
// - Closed switch reported as one regardless of polarity, except the input selected for analog, which reads zero.
// - Wake/interrupt enable zero blocks interrupt and wake; one enables both.
// - Codes 0x02 and 0x03 write wake/interrupt enables for prog and ground inputs.
// - Level bit zero selects 2 mA, one selects 16 mA; codes 0x04, 0x05.
// - Each input has its own 20 ms timer restarted by comparator change.
// - Timer expiry drops that input from 16 mA to 2 mA.
// - Disabled timer keeps 16 mA on without timeout.
// - Timer enable bits written by codes 0x07 and 0x08; zero disables.
// - High-impedance bit one turns source off, overriding level; codes 0x09, 0x0A.
// - High-impedance inputs keep comparing and reporting their state.
// - In Normal mode interrupt asserts only for enabled input changes.
// - Decoder recognises settings, wake, level, timer, hiz, analog, calibration, reset.
// - Frames are 24 bits MSB first, sampled on falling sclk, acted on at cs rise.
// - Reset sets battery polarity, all wake, 16 mA, timers on, hiz, no analog.
// - Status interrupt flag latched at chip-select falling edge.
`timescale 1ns/1ps
module sdc_core
  import sdc_pkg::*;
#(
  parameter int WET_CYCLES = WET_CYCLES_DEF
) (
  input wire logic mclk, // System clock, 200 MHz
  input wire logic rst, // Reset, active high
  input wire logic sclk, // SPI serial clock
  input wire logic cs_n, // SPI chip select, active low
  input wire logic si, // SPI data in
  output logic so, // SPI data out
  output logic so_oe_n, // SO driver enable, active low
  input wire logic [N_SW-1:0] sw_comp, // Comparator above threshold per input
  input wire logic vdd_ok, // Logic supply present
  input wire logic sleep_req, // Request to enter Sleep mode
  input wire logic int_timer_exp, // Interrupt timer expired
  input wire logic thermal_flag, // Thermal warning
  input wire logic int_in, // Interrupt pin level
  output logic int_out, // Interrupt pin drive value
  output logic int_oe_n, // Interrupt pin enable, active low
  input wire logic wake_in, // Wake pin level
  output logic wake_out, // Wake pin drive value
  output logic wake_oe_n, // Wake pin enable, active low
  output logic normal_mode, // High in Normal mode
  output logic [N_SW-1:0] cur_hi, // 16 mA source on per input
  output logic [N_SW-1:0] cur_off, // Source off per input
  output logic [N_PROG-1:0] polarity, // Programmable input polarity
  output logic [ASEL_W-1:0] analog_sel, // Analog channel select
  output logic [ACUR_W-1:0] analog_cur, // Analog current select
  output logic calib_start // One-cycle pulse on calibration command
);
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic [N_SW-1:0] sw_s1;
    logic [N_SW-1:0] sw_s2;
    logic [N_SW-1:0] closed_d;
    logic [2:0] prime;
    logic wake_s1;
    logic wake_s2;
    logic wake_d;
    logic int_s1;
    logic int_s2;
    logic int_d;
    logic vdd_s1;
    logic vdd_s2;
    logic slp_s1;
    logic slp_s2;
    logic slp_d;
    logic tmo_s1;
    logic tmo_s2;
    logic tmo_d;
    logic th_s1;
    logic th_s2;
    logic [CNT_W-1:0] cnt_s1;
    logic [CNT_W-1:0] cnt_s2;
    logic [FRAME_BITS-1:0] word_s1;
    logic [FRAME_BITS-1:0] word_s2;
    logic [CNT_W-1:0] base;
    logic [FRAME_BITS-1:0] status;
    sdc_mode_t mode;
    logic int_pend;
    logic chg_in_cs;
    logic [N_PROG-1:0] pol;
    logic [N_SW-1:0] wie;
    logic [N_SW-1:0] lvl;
    logic [N_SW-1:0] ten;
    logic [N_SW-1:0] hiz;
    logic [ASEL_W-1:0] asel;
    logic [ACUR_W-1:0] acur;
    logic cal;
    logic so_oe_n;
    logic [N_SW-1:0] cur_hi;
  } sdc_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [FRAME_BITS-1:0] sh;
  } sdc_link_t;

  sdc_state_t st_ff;
  sdc_state_t nxt_st;
  sdc_link_t lk_ff;
  sdc_link_t nxt_lk;
  logic so_ff;
  logic nxt_so;
  logic [N_SW-1:0] expired;

  // Replace the programmable or ground half of a per-input register
  function automatic logic [N_SW-1:0] upd_half(input logic [N_SW-1:0] old, input logic [FRAME_BITS-1:0] w,
                                                input logic gnd);
    logic [N_SW-1:0] r;
    r = old;
    if (gnd) begin
      r[N_GND-1:0] = w[N_GND-1:0];
    end else begin
      r[N_SW-1:PROG_LSB] = w[N_PROG-1:0];
    end
    return r;
  endfunction

  // Closed-switch view of the comparator outputs
  function automatic logic [N_SW-1:0] closed_of(input logic [N_SW-1:0] comp, input logic [N_PROG-1:0] pol);
    logic [N_SW-1:0] r;
    r[N_GND-1:0] = ~comp[N_GND-1:0];
    r[N_SW-1:PROG_LSB] = ~(comp[N_SW-1:PROG_LSB] ^ pol);
    return r;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < N_SW; gi++) begin : g_tmr
      sdc_wet_timer #(.CYCLES(WET_CYCLES)) u_tmr (
        .clk(mclk),
        .rst(rst),
        .comp(st_ff.sw_s2[gi]),
        .expired(expired[gi])
      );
    end
  endgenerate

  // Link side: shift in on falling sclk, counter free-runs across frames
  always_comb begin
    nxt_lk = lk_ff;
    nxt_lk.sh = {lk_ff.sh[FRAME_BITS-2:0], si};
    nxt_lk.cnt = lk_ff.cnt + CNT_W'(1);
  end

  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // Status bits leave MSB first on rising sclk; base and status are held since cs fall
  always_comb begin
    logic [CNT_W-1:0] idx;
    idx = lk_ff.cnt - st_ff.base;
    nxt_so = 1'b0;
    if (idx < FRAME_LEN) begin
      nxt_so = st_ff.status[5'(FRAME_BITS - 1) - idx[4:0]];
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      so_ff <= 1'b0;
    end else begin
      so_ff <= nxt_so;
    end
  end

  // System side
  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic [N_SW-1:0] closed;
    logic [N_SW-1:0] chg;
    logic ev;
    logic wake_ev;
    logic [CNT_W-1:0] nbits;
    logic [7:0] code;
    logic wr_ok;
    nxt_st = st_ff;
    nxt_st.cs_s1 = cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.cs_d = st_ff.cs_s2;
    nxt_st.sw_s1 = sw_comp;
    nxt_st.sw_s2 = st_ff.sw_s1;
    nxt_st.wake_s1 = wake_in;
    nxt_st.wake_s2 = st_ff.wake_s1;
    nxt_st.wake_d = st_ff.wake_s2;
    nxt_st.int_s1 = int_in;
    nxt_st.int_s2 = st_ff.int_s1;
    nxt_st.int_d = st_ff.int_s2;
    nxt_st.vdd_s1 = vdd_ok;
    nxt_st.vdd_s2 = st_ff.vdd_s1;
    nxt_st.slp_s1 = sleep_req;
    nxt_st.slp_s2 = st_ff.slp_s1;
    nxt_st.slp_d = st_ff.slp_s2;
    nxt_st.tmo_s1 = int_timer_exp;
    nxt_st.tmo_s2 = st_ff.tmo_s1;
    nxt_st.tmo_d = st_ff.tmo_s2;
    nxt_st.th_s1 = thermal_flag;
    nxt_st.th_s2 = st_ff.th_s1;
    nxt_st.cnt_s1 = lk_ff.cnt;
    nxt_st.cnt_s2 = st_ff.cnt_s1;
    nxt_st.word_s1 = lk_ff.sh;
    nxt_st.word_s2 = st_ff.word_s1;
    nxt_st.cal = 1'b0;
    nxt_st.so_oe_n = st_ff.cs_s2;
    nxt_st.prime = {st_ff.prime[1:0], 1'b1};

    cs_fall = st_ff.cs_d & ~st_ff.cs_s2;
    cs_rise = ~st_ff.cs_d & st_ff.cs_s2;
    closed = closed_of(st_ff.sw_s2, st_ff.pol);
    nxt_st.closed_d = closed;
    chg = closed ^ st_ff.closed_d;
    // Changes count only once the synchroniser and its delayed copy hold real samples,
    // so reset itself never raises the interrupt
    ev = |(chg & st_ff.wie) & st_ff.prime[2];

    // Mode changes
    wake_ev = ev | (st_ff.wake_d & ~st_ff.wake_s2) | (st_ff.tmo_s2 & ~st_ff.tmo_d) |
              (st_ff.int_d & ~st_ff.int_s2 & st_ff.wake_s2 & st_ff.vdd_s2) |
              (cs_fall & st_ff.vdd_s2);
    if (st_ff.mode == SDC_SLEEP) begin
      if (wake_ev) begin
        nxt_st.mode = SDC_NORMAL;
      end
    end else if (st_ff.slp_s2 & ~st_ff.slp_d) begin
      nxt_st.mode = SDC_SLEEP;
    end

    // Interrupt: change during cs low holds it across the release
    if (cs_fall) begin
      nxt_st.chg_in_cs = 1'b0;
    end
    if (ev & ~st_ff.cs_s2) begin
      nxt_st.chg_in_cs = 1'b1;
    end
    if (cs_rise & ~st_ff.chg_in_cs) begin
      nxt_st.int_pend = 1'b0;
    end
    if (ev & (st_ff.mode == SDC_NORMAL)) begin
      nxt_st.int_pend = 1'b1;
    end

    // Latch status at cs fall
    if (cs_fall) begin
      nxt_st.base = st_ff.cnt_s2;
      nxt_st.status = '0;
      nxt_st.status[N_SW-1:0] = closed;
      if (st_ff.asel != ASEL_RST) begin
        nxt_st.status[5'(st_ff.asel - ASEL_W'(1))] = 1'b0;
      end
      nxt_st.status[ST_INT_BIT] = st_ff.int_pend;
      nxt_st.status[ST_THERM_BIT] = st_ff.th_s2;
    end

    // Command at cs rise
    nbits = st_ff.cnt_s2 - st_ff.base;
    code = st_ff.word_s2[CMD_MSB:CMD_LSB];
    wr_ok = cs_rise & (st_ff.mode == SDC_NORMAL) & st_ff.vdd_s2 & (nbits == FRAME_LEN);
    if (wr_ok) begin
      case (code)
        CMD_POLARITY: nxt_st.pol = st_ff.word_s2[N_PROG-1:0];
        CMD_WIE_PROG: nxt_st.wie = upd_half(st_ff.wie, st_ff.word_s2, 1'b0);
        CMD_WIE_GND: nxt_st.wie = upd_half(st_ff.wie, st_ff.word_s2, 1'b1);
        CMD_LVL_PROG: nxt_st.lvl = upd_half(st_ff.lvl, st_ff.word_s2, 1'b0);
        CMD_LVL_GND: nxt_st.lvl = upd_half(st_ff.lvl, st_ff.word_s2, 1'b1);
        CMD_TEN_PROG: nxt_st.ten = upd_half(st_ff.ten, st_ff.word_s2, 1'b0);
        CMD_TEN_GND: nxt_st.ten = upd_half(st_ff.ten, st_ff.word_s2, 1'b1);
        CMD_HIZ_PROG: nxt_st.hiz = upd_half(st_ff.hiz, st_ff.word_s2, 1'b0);
        CMD_HIZ_GND: nxt_st.hiz = upd_half(st_ff.hiz, st_ff.word_s2, 1'b1);
        CMD_ANALOG: begin
          nxt_st.asel = st_ff.word_s2[ASEL_LSB +: ASEL_W];
          nxt_st.acur = st_ff.word_s2[ACUR_LSB +: ACUR_W];
        end
        CMD_CALIB: nxt_st.cal = 1'b1;
        CMD_RESET: begin
          nxt_st.pol = POL_RST;
          nxt_st.wie = WIE_RST;
          nxt_st.lvl = LVL_RST;
          nxt_st.ten = TEN_RST;
          nxt_st.hiz = HIZ_RST;
          nxt_st.asel = ASEL_RST;
          nxt_st.acur = ACUR_RST;
        end
        CMD_STATUS: nxt_st.cal = 1'b0;
        default: nxt_st.cal = 1'b0;
      endcase
    end

    // 16 mA where level is one, unless timed out with timer on or hiz is set
    nxt_st.cur_hi = st_ff.lvl & ~(st_ff.ten & expired) & ~st_ff.hiz;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.cs_s1 <= 1'b1;
      st_ff.cs_s2 <= 1'b1;
      st_ff.cs_d <= 1'b1;
      st_ff.wake_s1 <= 1'b1;
      st_ff.wake_s2 <= 1'b1;
      st_ff.wake_d <= 1'b1;
      st_ff.int_s1 <= 1'b1;
      st_ff.int_s2 <= 1'b1;
      st_ff.int_d <= 1'b1;
      st_ff.mode <= SDC_NORMAL;
      st_ff.pol <= POL_RST;
      st_ff.wie <= WIE_RST;
      st_ff.lvl <= LVL_RST;
      st_ff.ten <= TEN_RST;
      st_ff.hiz <= HIZ_RST;
      st_ff.asel <= ASEL_RST;
      st_ff.acur <= ACUR_RST;
      st_ff.so_oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign so = so_ff;
  assign so_oe_n = st_ff.so_oe_n;
  assign int_out = st_ff.cal & 1'b0;
  assign int_oe_n = ~st_ff.int_pend;
  assign wake_out = st_ff.cal & 1'b0;
  assign wake_oe_n = (st_ff.mode == SDC_SLEEP);
  assign normal_mode = (st_ff.mode == SDC_NORMAL);
  assign cur_hi = st_ff.cur_hi;
  assign cur_off = st_ff.hiz;
  assign polarity = st_ff.pol;
  assign analog_sel = st_ff.asel;
  assign analog_cur = st_ff.acur;
  assign calib_start = st_ff.cal;
endmodule

// ### inc/sdc_pkg.sv
// Constants shared by the switch-detect command block and its wetting timers.
// Assumes a 200 MHz system clock and a 24-bit SPI frame.
package sdc_pkg;
  localparam int N_SW = 22;
  localparam int N_PROG = 8;
  localparam int N_GND = 14;
  localparam int PROG_LSB = 14;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] FRAME_LEN = 8'h18;

  // Status word layout
  localparam int ST_INT_BIT = 23;
  localparam int ST_THERM_BIT = 22;

  // Command field position and codes
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 16;
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [7:0] CMD_POLARITY = 8'h01;
  localparam logic [7:0] CMD_WIE_PROG = 8'h02;
  localparam logic [7:0] CMD_WIE_GND = 8'h03;
  localparam logic [7:0] CMD_LVL_PROG = 8'h04;
  localparam logic [7:0] CMD_LVL_GND = 8'h05;
  localparam logic [7:0] CMD_ANALOG = 8'h06;
  localparam logic [7:0] CMD_TEN_PROG = 8'h07;
  localparam logic [7:0] CMD_TEN_GND = 8'h08;
  localparam logic [7:0] CMD_HIZ_PROG = 8'h09;
  localparam logic [7:0] CMD_HIZ_GND = 8'h0a;
  localparam logic [7:0] CMD_CALIB = 8'h0b;
  localparam logic [7:0] CMD_RESET = 8'h7f;

  // Analog select fields
  localparam int ASEL_LSB = 0;
  localparam int ASEL_W = 5;
  localparam int ACUR_LSB = 5;
  localparam int ACUR_W = 2;

  // Values after reset
  localparam logic [N_PROG-1:0] POL_RST = 8'hff;
  localparam logic [N_SW-1:0] WIE_RST = 22'h3fffff;
  localparam logic [N_SW-1:0] LVL_RST = 22'h3fffff;
  localparam logic [N_SW-1:0] TEN_RST = 22'h3fffff;
  localparam logic [N_SW-1:0] HIZ_RST = 22'h3fffff;
  localparam logic [ASEL_W-1:0] ASEL_RST = 5'h00;
  localparam logic [ACUR_W-1:0] ACUR_RST = 2'h0;

  // Wetting timer
  localparam int CLK_KHZ = 200000;
  localparam int WET_TIME_MS = 20;
  localparam int WET_CYCLES_DEF = WET_TIME_MS * CLK_KHZ;

  typedef enum logic {SDC_SLEEP, SDC_NORMAL} sdc_mode_t;
endpackage

// ### src/sdc_wet_timer.sv
// One wetting-current timer: restarts on every comparator change, flags expiry.
// Assumes comp is already synchronous to clk.
`timescale 1ns/1ps
module sdc_wet_timer
  import sdc_pkg::*;
#(
  parameter int CYCLES = WET_CYCLES_DEF
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic comp, // Comparator level
  output logic expired // Timer has run out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic prev;
    logic run;
    logic expired;
    logic [CW-1:0] cnt;
  } sdc_tmr_t;

  sdc_tmr_t st_ff;
  sdc_tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = comp;
    if (comp != st_ff.prev) begin
      nxt_st.cnt = '0;
      nxt_st.run = 1'b1;
      nxt_st.expired = 1'b0;
    end else if (st_ff.run) begin
      if (st_ff.cnt == LAST) begin
        nxt_st.run = 1'b0;
        nxt_st.expired = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{prev: 1'b0, run: 1'b1, expired: 1'b0, cnt: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign expired = st_ff.expired;
endmodule

// ### tb/sdc_core_chk.sv
// Concurrent checks on the switch-detect core ports, bound to every sdc_core.
// Assumes one mclk domain with synchronous active-high rst.
`timescale 1ns/1ps
module sdc_core_chk
  import sdc_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst, // Reset
  input wire logic cs_n, // Chip select
  input wire logic so_oe_n, // SO enable
  input wire logic vdd_ok, // Logic supply
  input wire logic [N_PROG-1:0] polarity, // Polarity
  input wire logic [N_SW-1:0] cur_off, // Source off
  input wire logic [N_SW-1:0] cur_hi, // High current
  input wire logic calib_start, // Calibration pulse
  input wire logic wake_in, // Wake wire
  input wire logic int_timer_exp, // Interrupt timer
  input wire logic normal_mode, // Mode
  input wire logic wake_oe_n, // Wake enable
  input wire logic wake_out, // Wake value
  input wire logic int_oe_n // Interrupt enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_SO_ON:
  assert property ($fell(cs_n) |-> ##[1:5] !so_oe_n) else $error("so driver not enabled after select");
  AST_SO_OFF:
  assert property ($rose(cs_n) |-> ##[1:5] so_oe_n) else $error("so driver not released after deselect");
  AST_CFG_AT_CS_RISE:
  assert property ($changed(polarity) |-> cs_n && $past(cs_n, 3)) else $error("polarity moved outside a frame end");
  AST_CFG_NO_VDD:
  assert property (!vdd_ok [*8] |=> $stable(polarity) && $stable(cur_off)) else $error("write taken without supply");
  AST_HIZ_WINS:
  assert property ((cur_hi & cur_off & $past(cur_off)) == 22'h000000) else $error("high current on a hiz input");
  AST_CALIB_PULSE:
  assert property (calib_start |=> !calib_start) else $error("calibration pulse too long");
  AST_WAKE_PIN:
  assert property ($fell(wake_in) && !normal_mode |-> ##[1:6] normal_mode) else $error("no wake on wake pin");
  AST_CS_WAKE:
  assert property ($fell(cs_n) && vdd_ok && !normal_mode |-> ##[1:6] normal_mode) else $error("no wake on select");
  AST_TMR_WAKE:
  assert property ($rose(int_timer_exp) && !normal_mode |-> ##[1:6] normal_mode) else $error("no wake on timer");
  AST_MODE_PIN:
  assert property (normal_mode [*3] |-> !wake_oe_n && !wake_out) else $error("wake pin not low in normal mode");
  AST_INT_CLEAR:
  assert property ($rose(int_oe_n) |-> cs_n && $past(cs_n, 2)) else $error("interrupt released while selected");
endmodule

bind sdc_core sdc_core_chk u_chk (.mclk(mclk), .rst(rst), .cs_n(cs_n), .so_oe_n(so_oe_n), .vdd_ok(vdd_ok),
  .polarity(polarity), .cur_off(cur_off), .cur_hi(cur_hi), .calib_start(calib_start), .wake_in(wake_in),
  .int_timer_exp(int_timer_exp), .normal_mode(normal_mode), .wake_oe_n(wake_oe_n), .wake_out(wake_out),
  .int_oe_n(int_oe_n));

// ### tb/sdc_host.sv
// Host controller model: SPI master sending frames and collecting the status word.
// Makes its own 6 ns serial clock, stopped between frames.
`timescale 1ns/1ps
module sdc_host (
  output logic sclk, // Serial clock, idle low
  output logic cs_n, // Chip select
  output logic si, // Data to the core
  input wire logic so // Data from the core
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Sends the low n bits of w, MSB first; r collects what came back
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = 32'h0;
    cs_n = 1'b0;
    #30;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      si = w[i];
      #3;
      sclk = 1'b0;
      r = {r[30:0], so};
      #3;
    end
    cs_n = 1'b1;
    si = ~si; // Released line must not keep showing the last bit
    #45;
  endtask
endmodule

// ### tb/sdc_core_tb_top.sv
// Self-checking bench for sdc_core with a host model on the SPI link.
// Assumes WET_CYCLES shortened to 50 and pull-ups on the interrupt and wake wires.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module sdc_core_tb_top;
  import sdc_pkg::*;
  typedef struct {logic [31:0] w; int n; logic [7:0] pol; logic [21:0] off; logic [6:0] an;} sdc_row_t;
  logic mclk = 1'b0, rst = 1'b1, vdd_ok = 1'b1, sleep_req = 1'b0, int_timer_exp = 1'b0, thermal_flag = 1'b1;
  logic int_ext = 1'b1, wake_ext = 1'b1, int_in, wake_in, sclk, cs_n, si, so, so_oe_n, int_out, int_oe_n;
  logic wake_out, wake_oe_n, normal_mode, calib_start;
  logic [N_SW-1:0] sw_comp = 22'h003fff, cur_hi, cur_off;
  logic [7:0] polarity;
  logic [4:0] analog_sel;
  logic [1:0] analog_cur;
  logic [31:0] resp;
  logic [23:0] cfg_seq[6] = '{24'h0a0000, 24'h090000, 24'h08000f, 24'h050013, 24'h0700ff, 24'h04000f};
  int fail_count = 0, compares = 0, calib_cnt = 0;
  sdc_row_t rows[10] = '{
    '{32'h0100a5, 24, 8'ha5, 22'h3fffff, 7'h00},
    '{32'h0a1234, 24, 8'ha5, 22'h3fd234, 7'h00},
    '{32'h09003c, 24, 8'ha5, 22'h0f1234, 7'h00},
    '{32'h0cffff, 24, 8'ha5, 22'h0f1234, 7'h00},
    '{32'h008008, 23, 8'ha5, 22'h0f1234, 7'h00},
    '{32'h020022, 25, 8'ha5, 22'h0f1234, 7'h00},
    '{32'h060055, 24, 8'ha5, 22'h0f1234, 7'h55},
    '{32'h01ff00, 24, 8'h00, 22'h0f1234, 7'h55},
    '{32'h0b0000, 24, 8'h00, 22'h0f1234, 7'h55},
    '{32'h7f0000, 24, 8'hff, 22'h3fffff, 7'h00}};
  assign int_in = int_oe_n ? int_ext : 1'b0;
  assign wake_in = wake_oe_n ? wake_ext : 1'b0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (calib_start) calib_cnt++;
  end
  sdc_host u_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  sdc_core #(.WET_CYCLES(50)) u_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe_n(so_oe_n), .sw_comp(sw_comp), .vdd_ok(vdd_ok), .sleep_req(sleep_req), .int_timer_exp(int_timer_exp),
    .thermal_flag(thermal_flag), .int_in(int_in), .int_out(int_out), .int_oe_n(int_oe_n), .wake_in(wake_in),
    .wake_out(wake_out), .wake_oe_n(wake_oe_n), .normal_mode(normal_mode), .cur_hi(cur_hi), .cur_off(cur_off),
    .polarity(polarity), .analog_sel(analog_sel), .analog_cur(analog_cur), .calib_start(calib_start));
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [31:0] w);
    u_host.xfer(w, 24, resp);
    wt(10);
  endtask
  task automatic end_sim();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    wt(4);
    rst = 1'b0;
    wt(4);
    foreach (rows[i]) begin
      u_host.xfer(rows[i].w, rows[i].n, resp);
      wt(10);
      `CHK(polarity, rows[i].pol)
      `CHK(cur_off, rows[i].off)
      `CHK({analog_cur, analog_sel}, rows[i].an)
    end
    `CHK(calib_cnt, 1)
    $display("test table done");
    rst = 1'b1;
    wt(4);
    rst = 1'b0;
    wt(2);
    `CHK({polarity, cur_off, cur_hi}, {8'hff, 22'h3fffff, 22'h0})
    `CHK({analog_sel, analog_cur, normal_mode, int_oe_n, so_oe_n, wake_oe_n}, 11'h00e)
    $display("test reset done");
    foreach (cfg_seq[i]) wr({8'h0, cfg_seq[i]});
    wt(60);
    `CHK(cur_hi, 22'h000010)
    sw_comp[0] = 1'b0;
    wt(40);
    `CHK(cur_hi, 22'h000011)
    wt(30);
    `CHK(cur_hi, 22'h000010)
    wr(32'h0a0011);
    `CHK({cur_hi, cur_off}, {22'h000000, 22'h000011})
    $display("test wetting done");
    wr(32'h030000);
    wr(32'h020000);
    wr(32'h0100fe);
    wr(32'h000000);
    `CHK(int_oe_n, 1'b1)
    sw_comp[5] = 1'b0;
    wt(10);
    `CHK(int_oe_n, 1'b1)
    wr(32'h030020);
    sw_comp[5] = 1'b1;
    wt(10);
    `CHK({int_oe_n, int_out}, 2'b00)
    sw_comp[5] = 1'b0;
    wt(4);
    wr(32'h000000);
    `CHK(resp[23:0], 24'hc04021)
    `CHK(int_oe_n, 1'b1)
    fork
      u_host.xfer(32'h0, 24, resp);
      begin
        wt(12);
        sw_comp[5] = 1'b1;
      end
    join
    wt(10);
    `CHK(int_oe_n, 1'b0)
    $display("test interrupt done");
    wr(32'h000000);
    vdd_ok = 1'b0;
    wr(32'h0100aa);
    vdd_ok = 1'b1;
    `CHK(polarity, 8'hfe)
    for (int k = 0; k < 5; k++) begin
      sleep_req = 1'b1;
      wt(10);
      sleep_req = 1'b0;
      `CHK({normal_mode, wake_oe_n}, 2'b01)
      case (k)
        0: wake_ext = 1'b0;
        1: int_timer_exp = 1'b1;
        2: int_ext = 1'b0;
        3: u_host.xfer(32'h0, 24, resp);
        default: sw_comp[5] = 1'b0;
      endcase
      wt(10);
      `CHK(normal_mode, 1'b1)
      wake_ext = 1'b1;
      int_timer_exp = 1'b0;
      int_ext = 1'b1;
    end
    $display("test sleep done");
    end_sim();
  end
endmodule
